// ===== src/mbt_map.svh
`ifndef MBT_MAP_SVH
`define MBT_MAP_SVH
// ----------------------------------------
// clock and time bases
// ----------------------------------------
`define MBT_CLK_NS 10
`define MBT_CLK_HZ 100000000
`define MBT_MS_NS 1000000
`define MBT_US_NS 1000
// half-bit ticks per half character: 11-bit character
`define MBT_HALF_BITS 4'hB
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MBT_OFS_CTRL 8'h00
`define MBT_OFS_START 8'h04
`define MBT_OFS_RETRY 8'h08
`define MBT_OFS_RESP 8'h0C
`define MBT_OFS_IFD 8'h10
`define MBT_OFS_ICT 8'h14
`define MBT_OFS_BAUD 8'h18
`define MBT_OFS_STATUS 8'h1C
// ----------------------------------------
// reset values and ranges
// ----------------------------------------
`define MBT_RST_START 17'h00000
`define MBT_RST_RETRY 3'h3
`define MBT_RST_RESP 17'h003E8
`define MBT_RST_BAUD 24'h002580
`define MBT_MAX_START 17'h07530
`define MBT_MAX_RETRY 3'h5
`define MBT_MIN_RESP 17'h0000A
`define MBT_MAX_RESP 17'h1D4C0
`define MBT_MIN_GAP 17'h0000A
`define MBT_MAX_GAP 17'h001F4
// ----------------------------------------
// gap defaults
// ----------------------------------------
`define MBT_BAUD_LIMIT 24'h004B00
`define MBT_IFD_HALF 17'h00007
`define MBT_ICT_HALF 17'h00003
`define MBT_FAST_IFD_US 17'h006D6
`define MBT_FAST_ICT_US 17'h002EE
`endif

// ===== src/mbt_pkg.sv
`default_nettype none
package mbt_pkg;
    typedef enum logic [2:0] {st_init, st_idle, st_send, st_wait, st_gap} mbt_state_e;
    typedef enum logic [1:0] {unit_ms, unit_half, unit_us} mbt_unit_e;
    typedef struct packed {
        mbt_unit_e unit;
        logic [16:0] count;
    } mbt_lim_s;
    typedef struct packed {
        logic [27:0] acc;
        logic [19:0] ms_cnt;
        logic [11:0] us_cnt;
        logic [3:0] hbit;
        logic ms_tick;
        logic us_tick;
        logic half_tick;
    } mbt_tick_s;
    typedef struct packed {
        mbt_state_e state;
        logic mode;
        logic [16:0] start_cfg;
        logic [2:0] retry_cfg;
        logic [16:0] resp_cfg;
        logic [16:0] ifd_cfg;
        logic [16:0] ict_cfg;
        logic [23:0] baud_cfg;
        logic [16:0] tmr_cnt;
        logic [16:0] ich_cnt;
        logic [2:0] attempt;
        logic rx_active;
        logic rx_drop;
        logic [7:0] tmo_total;
        logic [7:0] drop_total;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tx_start;
        logic req_take;
        logic resp_ok;
        logic timeout;
        logic discard;
    } mbt_regs_s;
endpackage
`default_nettype wire

// ===== src/mbt_tick.sv
`include "mbt_map.svh"
`default_nettype none
module mbt_tick #(
    parameter int MS_CYCLES = `MBT_MS_NS / `MBT_CLK_NS,
    parameter int US_CYCLES = `MBT_US_NS / `MBT_CLK_NS,
    parameter int CLK_HZ = `MBT_CLK_HZ
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // rate
    input wire logic [23:0] baud_in,
    // ticks
    output logic ms_tick_out,
    output logic us_tick_out,
    output logic half_char_out
);
    mbt_pkg::mbt_tick_s t_reg;
    mbt_pkg::mbt_tick_s t_next;

    always_comb begin
        logic [28:0] sum;
        sum = {1'b0, t_reg.acc} + {4'h0, baud_in, 1'b0};
        t_next = t_reg;
        t_next.ms_tick = 1'b0;
        t_next.us_tick = 1'b0;
        t_next.half_tick = 1'b0;
        // fractional accumulator: one step per half bit, no divider needed
        if (sum >= 29'(CLK_HZ)) begin
            t_next.acc = 28'(sum - 29'(CLK_HZ));
            if (t_reg.hbit == `MBT_HALF_BITS - 4'h1) begin
                t_next.hbit = 4'h0;
                t_next.half_tick = 1'b1;
            end else begin
                t_next.hbit = t_reg.hbit + 4'h1;
            end
        end else begin
            t_next.acc = sum[27:0];
        end
        if (t_reg.ms_cnt == 20'(MS_CYCLES - 1)) begin
            t_next.ms_cnt = 20'h00000;
            t_next.ms_tick = 1'b1;
        end else begin
            t_next.ms_cnt = t_reg.ms_cnt + 20'h00001;
        end
        if (t_reg.us_cnt == 12'(US_CYCLES - 1)) begin
            t_next.us_cnt = 12'h000;
            t_next.us_tick = 1'b1;
        end else begin
            t_next.us_cnt = t_reg.us_cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign ms_tick_out = t_reg.ms_tick;
    assign us_tick_out = t_reg.us_tick;
    assign half_char_out = t_reg.half_tick;
endmodule
`default_nettype wire

// ===== src/mbt_timing.sv
// The APB slave port and the register addresses are this design's own decisions.
`include "mbt_map.svh"
`default_nettype none

module mbt_timing #(
    parameter int MS_CYCLES = `MBT_MS_NS / `MBT_CLK_NS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // request queue and transmitter
    input wire logic req_valid_in,
    input wire logic tx_done_in,
    output logic tx_start_out,
    output logic req_take_out,
    // receiver
    input wire logic rx_char_in,
    input wire logic rx_frame_end_in,
    // status
    output logic ascii_mode_out,
    output logic resp_ok_out,
    output logic timeout_out,
    output logic discard_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [16:0] clamp17(input logic [16:0] v, input logic [16:0] lo,
                                            input logic [16:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [16:0] gap_cfg(input logic [31:0] w);
        // zero keeps the character-based default
        if (w[31:17] != 15'h0000 || w[16:0] > `MBT_MAX_GAP) begin
            return `MBT_MAX_GAP;
        end else if (w[16:0] == 17'h00000) begin
            return 17'h00000;
        end
        return clamp17(w[16:0], `MBT_MIN_GAP, `MBT_MAX_GAP);
    endfunction

    function automatic mbt_pkg::mbt_lim_s gap_lim(input logic [16:0] cfg, input logic [23:0] baud,
                                                  input logic [16:0] halves, input logic [16:0] fast_us);
        mbt_pkg::mbt_lim_s l;
        if (baud > `MBT_BAUD_LIMIT) begin
            l.unit = mbt_pkg::unit_us;
            l.count = fast_us;
        end else if (cfg == 17'h00000) begin
            l.unit = mbt_pkg::unit_half;
            l.count = halves;
        end else begin
            l.unit = mbt_pkg::unit_ms;
            l.count = cfg;
        end
        return l;
    endfunction

    function automatic logic tick_sel(input mbt_pkg::mbt_unit_e u, input logic ms, input logic half,
                                      input logic us);
        case (u)
            mbt_pkg::unit_ms: return ms;
            mbt_pkg::unit_half: return half;
            mbt_pkg::unit_us: return us;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [16:0] inc17(input logic [16:0] v);
        return (v == 17'h1FFFF) ? v : v + 17'h00001;
    endfunction

    // ----------------------------------------
    // time bases
    // ----------------------------------------
    mbt_pkg::mbt_regs_s s_reg;
    mbt_pkg::mbt_regs_s s_next;
    mbt_pkg::mbt_lim_s lim_ifd;
    mbt_pkg::mbt_lim_s lim_ict;
    logic ms_tick;
    logic us_tick;
    logic half_tick;

    mbt_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .baud_in(s_reg.baud_cfg),
        .ms_tick_out(ms_tick),
        .us_tick_out(us_tick),
        .half_char_out(half_tick)
    );

    assign lim_ifd = gap_lim(s_reg.ifd_cfg, s_reg.baud_cfg, `MBT_IFD_HALF, `MBT_FAST_IFD_US);
    assign lim_ict = gap_lim(s_reg.ict_cfg, s_reg.baud_cfg, `MBT_ICT_HALF, `MBT_FAST_ICT_US);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic frame_good;
        logic ich_tick;
        frame_good = 1'b0;
        ich_tick = tick_sel(lim_ict.unit, ms_tick, half_tick, us_tick);
        s_next = s_reg;
        s_next.tx_start = 1'b0;
        s_next.req_take = 1'b0;
        s_next.resp_ok = 1'b0;
        s_next.timeout = 1'b0;
        s_next.discard = 1'b0;
        s_next.pready = 1'b0;

        // apb: answer one cycle into the access phase, write lands on that edge
        if (psel_in && penable_in && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = 1'b0;
            s_next.prdata = 32'h00000000;
            case (paddr_in)
                `MBT_OFS_CTRL: s_next.prdata = {31'h00000000, s_reg.mode};
                `MBT_OFS_START: s_next.prdata = {15'h0000, s_reg.start_cfg};
                `MBT_OFS_RETRY: s_next.prdata = {29'h00000000, s_reg.retry_cfg};
                `MBT_OFS_RESP: s_next.prdata = {15'h0000, s_reg.resp_cfg};
                `MBT_OFS_IFD: s_next.prdata = {15'h0000, s_reg.ifd_cfg};
                `MBT_OFS_ICT: s_next.prdata = {15'h0000, s_reg.ict_cfg};
                `MBT_OFS_BAUD: s_next.prdata = {8'h00, s_reg.baud_cfg};
                `MBT_OFS_STATUS: s_next.prdata = {s_reg.drop_total, s_reg.tmo_total, 7'h00, s_reg.rx_drop,
                                                  s_reg.rx_active, s_reg.attempt, 1'b0, s_reg.state};
                default: s_next.pslverr = 1'b1;
            endcase
        end
        if (psel_in && penable_in && s_reg.pready && pwrite_in) begin
            case (paddr_in)
                `MBT_OFS_CTRL: s_next.mode = pwdata_in[0];
                `MBT_OFS_START: begin
                    s_next.start_cfg = (pwdata_in[31:17] != 15'h0000) ? `MBT_MAX_START
                                     : clamp17(pwdata_in[16:0], 17'h00000, `MBT_MAX_START);
                end
                `MBT_OFS_RETRY: begin
                    s_next.retry_cfg = (pwdata_in[31:3] != 29'h00000000 || pwdata_in[2:0] > `MBT_MAX_RETRY)
                                     ? `MBT_MAX_RETRY : pwdata_in[2:0];
                end
                `MBT_OFS_RESP: begin
                    s_next.resp_cfg = (pwdata_in[31:17] != 15'h0000) ? `MBT_MAX_RESP
                                    : clamp17(pwdata_in[16:0], `MBT_MIN_RESP, `MBT_MAX_RESP);
                end
                `MBT_OFS_IFD: s_next.ifd_cfg = gap_cfg(pwdata_in);
                `MBT_OFS_ICT: s_next.ict_cfg = gap_cfg(pwdata_in);
                `MBT_OFS_BAUD: s_next.baud_cfg = pwdata_in[23:0];
                default: s_next.mode = s_reg.mode;
            endcase
        end

        // receive frame watch; ascii has no character timeout
        if (rx_frame_end_in) begin
            frame_good = s_reg.rx_active && !s_reg.rx_drop;
            s_next.rx_active = 1'b0;
            s_next.rx_drop = 1'b0;
            s_next.ich_cnt = 17'h00000;
        end else if (rx_char_in) begin
            s_next.rx_active = 1'b1;
            s_next.ich_cnt = 17'h00000;
        end else if (s_reg.rx_active) begin
            if (!s_reg.mode && !s_reg.rx_drop && s_reg.ich_cnt > lim_ict.count) begin
                // rest of the frame is swallowed until its end marker
                s_next.rx_drop = 1'b1;
                s_next.discard = 1'b1;
                s_next.drop_total = s_reg.drop_total + 8'h01;
            end else if (ich_tick) begin
                s_next.ich_cnt = inc17(s_reg.ich_cnt);
            end
        end

        // request sequencing
        case (s_reg.state)
            mbt_pkg::st_init: begin
                if (s_reg.tmr_cnt >= s_reg.start_cfg) begin
                    s_next.state = mbt_pkg::st_idle;
                    s_next.tmr_cnt = 17'h00000;
                end else if (ms_tick) begin
                    s_next.tmr_cnt = inc17(s_reg.tmr_cnt);
                end
            end
            mbt_pkg::st_idle: begin
                if (req_valid_in) begin
                    s_next.state = mbt_pkg::st_send;
                    s_next.tx_start = 1'b1;
                    s_next.attempt = 3'h1;
                end
            end
            mbt_pkg::st_send: begin
                if (tx_done_in) begin
                    s_next.state = mbt_pkg::st_wait;
                    s_next.tmr_cnt = 17'h00000;
                end
            end
            mbt_pkg::st_wait: begin
                if (frame_good) begin
                    s_next.resp_ok = 1'b1;
                    s_next.req_take = 1'b1;
                    s_next.attempt = 3'h0;
                    s_next.tmr_cnt = 17'h00000;
                    s_next.state = s_reg.mode ? mbt_pkg::st_idle : mbt_pkg::st_gap;
                // one extra tick so a partial first tick never shortens the wait
                end else if (s_reg.tmr_cnt > s_reg.resp_cfg) begin
                    if (s_reg.attempt <= s_reg.retry_cfg) begin
                        // same request again; queue is not advanced
                        s_next.state = mbt_pkg::st_send;
                        s_next.tx_start = 1'b1;
                        s_next.attempt = s_reg.attempt + 3'h1;
                    end else begin
                        s_next.state = mbt_pkg::st_idle;
                        s_next.timeout = 1'b1;
                        s_next.req_take = 1'b1;
                        s_next.attempt = 3'h0;
                        s_next.tmo_total = s_reg.tmo_total + 8'h01;
                    end
                end else if (ms_tick) begin
                    s_next.tmr_cnt = inc17(s_reg.tmr_cnt);
                end
            end
            mbt_pkg::st_gap: begin
                if (s_reg.tmr_cnt > lim_ifd.count) begin
                    s_next.state = mbt_pkg::st_idle;
                end else if (tick_sel(lim_ifd.unit, ms_tick, half_tick, us_tick)) begin
                    s_next.tmr_cnt = inc17(s_reg.tmr_cnt);
                end
            end
            default: s_next.state = mbt_pkg::st_idle;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_reg <= '0;
            s_reg.state <= mbt_pkg::st_init;
            s_reg.mode <= 1'b0;
            s_reg.start_cfg <= `MBT_RST_START;
            s_reg.retry_cfg <= `MBT_RST_RETRY;
            s_reg.resp_cfg <= `MBT_RST_RESP;
            s_reg.baud_cfg <= `MBT_RST_BAUD;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata_out = s_reg.prdata;
    assign pready_out = s_reg.pready;
    assign pslverr_out = s_reg.pslverr;
    assign tx_start_out = s_reg.tx_start;
    assign req_take_out = s_reg.req_take;
    assign ascii_mode_out = s_reg.mode;
    assign resp_ok_out = s_reg.resp_ok;
    assign timeout_out = s_reg.timeout;
    assign discard_out = s_reg.discard;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_ascii_no_drop: assert property (discard_out |-> !ascii_mode_out)
        else $error("frame discarded in ascii mode");
    chk_start_hold: assert property ((s_reg.state == mbt_pkg::st_init ##1 s_reg.state != mbt_pkg::st_init)
        |-> $past(s_reg.tmr_cnt) >= $past(s_reg.start_cfg))
        else $error("start delay cut short");
    chk_retry_resend: assert property ((s_reg.state == mbt_pkg::st_wait && !rx_frame_end_in
        && s_reg.tmr_cnt > s_reg.resp_cfg && s_reg.attempt <= s_reg.retry_cfg)
        |=> tx_start_out && s_reg.state == mbt_pkg::st_send)
        else $error("retry not sent");
    chk_resp_wait: assert property (timeout_out |-> $past(s_reg.state) == mbt_pkg::st_wait
        && $past(s_reg.tmr_cnt) >= $past(s_reg.resp_cfg))
        else $error("timeout before response time");
    chk_gap_held: assert property ((s_reg.state == mbt_pkg::st_gap && s_reg.tmr_cnt < lim_ifd.count)
        |=> s_reg.state == mbt_pkg::st_gap)
        else $error("gap left early");
    chk_slow_ifd: assert property ((s_reg.baud_cfg <= `MBT_BAUD_LIMIT && s_reg.ifd_cfg == 17'h00000)
        |-> lim_ifd.unit == mbt_pkg::unit_half && lim_ifd.count == `MBT_IFD_HALF)
        else $error("default gap not 3.5 characters");
    chk_fast_fixed: assert property (s_reg.baud_cfg > `MBT_BAUD_LIMIT |-> lim_ifd.unit == mbt_pkg::unit_us
        && lim_ict.unit == mbt_pkg::unit_us && lim_ict.count == `MBT_FAST_ICT_US)
        else $error("fast baud not using fixed gaps");
    chk_slow_ict: assert property ((s_reg.baud_cfg <= `MBT_BAUD_LIMIT && s_reg.ict_cfg == 17'h00000)
        |-> lim_ict.unit == mbt_pkg::unit_half && lim_ict.count == `MBT_ICT_HALF)
        else $error("default char timeout not 1.5 characters");
    chk_drop_late: assert property (discard_out |-> $past(s_reg.ich_cnt) > $past(lim_ict.count)
        && !$past(rx_char_in))
        else $error("discard without late character");
    chk_final_report: assert property (timeout_out |-> req_take_out && s_reg.state == mbt_pkg::st_idle
        && $past(s_reg.attempt) > $past(s_reg.retry_cfg))
        else $error("timeout reported with retries left");
endmodule
`default_nettype wire

// ===== bench/mbt_slave_model.sv
`default_nettype none
module mbt_slave_model (
    // clock
    input wire logic clk_in,
    // from the master
    input wire logic tx_start_in,
    // behaviour chosen by the bench
    input wire logic answer_in,
    input wire logic [15:0] gap_in,
    // to the master
    output logic tx_done_out,
    output logic rx_char_out,
    output logic rx_frame_end_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tx_done_out = 1'b0;
        rx_char_out = 1'b0;
        rx_frame_end_out = 1'b0;
    end

    // ----------------------------------------
    // transmit, then answer with three characters
    // ----------------------------------------
    // a silent slave only finishes the send, so the master must time out
    always begin
        @(posedge clk_in);
        if (tx_start_in === 1'b1) begin
            repeat (3) @(posedge clk_in);
            tx_done_out <= 1'b1;
            @(posedge clk_in);
            tx_done_out <= 1'b0;
            if (answer_in) begin
                repeat (6) @(posedge clk_in);
                repeat (3) begin
                    rx_char_out <= 1'b1;
                    @(posedge clk_in);
                    rx_char_out <= 1'b0;
                    repeat (gap_in) @(posedge clk_in);
                end
                rx_frame_end_out <= 1'b1;
                @(posedge clk_in);
                rx_frame_end_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_modbus_serial_master_timing.sv
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_modbus_serial_master_timing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] OF[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    localparam logic [31:0] RV[9] = '{32'h0, 32'h0, 32'h3, 32'h3E8, 32'h0, 32'h0, 32'h2580, 32'h1, 32'h0};
    localparam logic [31:0] LO[5] = '{32'h0, 32'h0, 32'hA, 32'hA, 32'hA};
    localparam logic [31:0] HI[5] = '{32'h7530, 32'h5, 32'h1D4C0, 32'h1F4, 32'h1F4};
    localparam logic [31:0] MX[5] = '{32'h1FFFF, 32'h7, 32'h1FFFF, 32'h3FF, 32'h3FF};
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, req_valid_in = 1'b0, answer = 1'b1;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd, v;
    logic [15:0] gap = 16'h0005;
    logic pready_out, pslverr_out, tx_start_out, req_take_out, ascii_mode_out, resp_ok_out, timeout_out;
    logic discard_out, tx_done_in, rx_char_in, rx_frame_end_in, er;
    int fails = 0, num_checks = 0, cyc = 0, d, t;
    int ev[5], evc[5], e0[5];
    wire logic [4:0] pulse = {discard_out, timeout_out, resp_ok_out, req_take_out, tx_start_out};

    always #5 clk_in = ~clk_in;

    // ms tick shortened so timeouts take hundreds of cycles, not millions
    mbt_timing #(.MS_CYCLES(20)) uut (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .req_valid_in(req_valid_in),
        .tx_done_in(tx_done_in),
        .tx_start_out(tx_start_out),
        .req_take_out(req_take_out),
        .rx_char_in(rx_char_in),
        .rx_frame_end_in(rx_frame_end_in),
        .ascii_mode_out(ascii_mode_out),
        .resp_ok_out(resp_ok_out),
        .timeout_out(timeout_out),
        .discard_out(discard_out)
    );

    mbt_slave_model far_end (
        .clk_in(clk_in),
        .tx_start_in(tx_start_out),
        .answer_in(answer),
        .gap_in(gap),
        .tx_done_out(tx_done_in),
        .rx_char_out(rx_char_in),
        .rx_frame_end_out(rx_frame_end_in)
    );

    // ----------------------------------------
    // event counters and time stamps
    // ----------------------------------------
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 5; k++) begin
            if (pulse[k] === 1'b1) begin
                ev[k] <= ev[k] + 1;
                evc[k] <= cyc;
            end
        end
    end

    function automatic logic [31:0] clampv(logic [31:0] x, logic [31:0] lo, logic [31:0] hi, bit zero_ok);
        if (zero_ok && x == 32'h0) return 32'h0;
        return (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= dat;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) fails++;
        @(posedge clk_in);
    endtask

    task automatic wait_ev(input int k, input int tgt, input int lim);
        int n = 0;
        while (ev[k] < tgt && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        if (ev[k] < tgt) fails++;
    endtask

    // one request: queue holds it until the master starts sending
    task automatic req(input int lim);
        t = cyc;
        e0 = ev;
        req_valid_in <= 1'b1;
        wait_ev(0, e0[0] + 1, 600);
        req_valid_in <= 1'b0;
        wait_ev(1, e0[1] + 1, lim);
    endtask

    task automatic pair(output int dd);
        int r;
        req(400);
        r = evc[2];
        req(400);
        dd = evc[0] - r;
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        fails++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(74173));
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        `CHK("mode", 1'b0, ascii_mode_out)
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, OF[i], 32'h0);
            `CHK("reset_value", RV[i], rd)
            `CHK("slverr", (i == 8), er)
        end
        // first two passes hit the range ends, the rest are random
        for (int n = 0; n < 8; n++) begin
            for (int i = 0; i < 5; i++) begin
                v = (n == 0) ? 32'h0 : ((n == 1) ? MX[i] : $urandom_range(MX[i], 0));
                apb(1'b1, OF[i + 1], v);
                apb(1'b0, OF[i + 1], 32'h0);
                `CHK("clamp", clampv(v, LO[i], HI[i], i > 2), rd)
            end
        end
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'hA);
        apb(1'b1, 8'h10, 32'hA);
        apb(1'b1, 8'h14, 32'hA);
        req(400);
        `CHK("start_hold", 1'b1, evc[0] - t <= 4)
        `CHK("answered", 1, ev[2] - e0[2])
        pair(d);
        `CHK("rtu_gap", 1'b1, d >= 190 && d <= 240)
        apb(1'b1, 8'h00, 32'h1);
        `CHK("mode", 1'b1, ascii_mode_out)
        pair(d);
        `CHK("ascii_gap", 1'b1, d < 20)
        apb(1'b1, 8'h00, 32'h0);
        answer <= 1'b0;
        for (int r = 0; r < 6; r++) begin
            apb(1'b1, 8'h08, 32'(r));
            req(300 * r + 400);
            `CHK("sends", r + 1, ev[0] - e0[0])
            `CHK("tmo_take", evc[1], evc[3])
            `CHK("tmo", 1, ev[3] - e0[3])
            `CHK("resp_time", 1'b1, evc[3] - evc[0] >= 190 && evc[3] - evc[0] <= 240)
        end
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("tmo_count", 8'h06, rd[23:16])
        answer <= 1'b1;
        gap <= 16'h012C;
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'h32);
        req(1400);
        `CHK("discard", 1, ev[4] - e0[4])
        `CHK("dropped_ok", 0, ev[2] - e0[2])
        gap <= 16'h0064;
        req(1400);
        `CHK("kept", 0, ev[4] - e0[4])
        `CHK("kept_ok", 1, ev[2] - e0[2])
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("drop_count", 8'h01, rd[31:24])
        tally_and_finish();
    end
endmodule
`default_nettype wire
